/* include/lbrs_pkg.sv */
// How it works
// - Analog rail 7 V to 10.1 V, default 8.4.
// - Core rail 1.0 V to 1.3 V, default 1.1.
// - Core, primary I/O, LDO start at lockout release.
// - Logic rails ramp in 0.5 to 4 ms.
// - One logic soft-start time for all three.
// - Core rail off at lockout, no discharge.
// - Primary I/O 1.7, 1.8 or 2.5 V, default 1.7.
// - LDO stays off when primary is 1.7/1.8 V.
// - LDO on only at 2.5 V, 1.7/1.8 V out.
// - Primary I/O off and discharged at lockout.
// - Gate rail starts after analog rail ramp ends.
// - Both boost rails share 4 to 7.5 ms ramp.
// - Gate rail off on enable low or lockout.
// - Gate rail latched off after enable low.
// - Gate rail has no discharge when disabled.
// - Cold gate level spans 25 V to 40 V.
// - Hot gate level spans 16 V to 31 V.
// - Grounded thermistor input means hot level only.
// - Analog rail starts 0-70 ms after enable/reset.
// - Analog rail latched off after enable low.
package lbrs_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CNT_W = 22;

  // Logic soft start: code 0..7 gives 0.5 ms..4 ms.
  localparam int LSS_STEP_US = 500;
  localparam int LSS_STEP_CYC = LSS_STEP_US * CYC_PER_US;
  // Boost soft start: code 0..7 gives 4 ms..7.5 ms.
  localparam int BSS_MIN_US = 4000;
  localparam int BSS_MIN_CYC = BSS_MIN_US * CYC_PER_US;
  localparam int BSS_STEP_US = 500;
  localparam int BSS_STEP_CYC = BSS_STEP_US * CYC_PER_US;
  // Analog start delay: code 0..7 gives 0 ms..70 ms.
  localparam int DLY_STEP_US = 10000;
  localparam int DLY_STEP_CYC = DLY_STEP_US * CYC_PER_US;

  localparam int AV_W = 5;
  localparam int CORE_W = 2;
  localparam int IO_W = 2;
  localparam int SS_W = 3;
  localparam int DLY_W = 3;
  localparam int GH_W = 4;

  // Analog code n is 7.0 V + n * 100 mV; 14 is 8.4 V.
  localparam logic [4:0] AV_DEF = 5'h0e;
  // Core code n is 1.0 V + n * 100 mV; 1 is 1.1 V.
  localparam logic [1:0] CORE_DEF = 2'h1;
  // I/O select: 0 is 1.7 V, 1 is 1.8 V, 2 and 3 are 2.5 V
  // with the LDO at 1.7 V or 1.8 V.
  localparam logic [1:0] IO_DEF = 2'h0;
  localparam int IO_LDO_BIT = 1;
  localparam logic [1:0] IO1_OUT_2V5 = 2'h2;
  // Gate codes: cold n is 25 V + n V, hot n is 16 V + n V.
  localparam logic [3:0] GH_DEF = 4'h0;

  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_WAIT = 7'h02,
    ST_DELAY = 7'h04,
    ST_AV_RAMP = 7'h08,
    ST_GH_RAMP = 7'h10,
    ST_RUN = 7'h20,
    ST_SHUT = 7'h40
  } lbrs_state_t;
endpackage : lbrs_pkg

/* logic/lbrs_rst_sync.sv */
`timescale 1ns/10ps
module lbrs_rst_sync (
  input wire logic clk,
  input wire logic rst_async_n,
  output logic rst_n
);
  import lbrs_pkg::*;
  logic meta_q;
  logic sync_q;
  always_ff @(posedge clk or negedge rst_async_n) begin
    if (!rst_async_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      sync_q <= meta_q;
    end
  end
  assign rst_n = sync_q;
endmodule : lbrs_rst_sync

/* logic/lbrs_timer.sv */
`timescale 1ns/10ps
module lbrs_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [lbrs_pkg::CNT_W-1:0] limit,
  output logic done
);
  import lbrs_pkg::*;
  // Done rises limit+1 cycles after run is first seen high,
  // holds while run stays high, and clears when run drops.
  logic [CNT_W-1:0] cnt_q;
  logic done_q;
  logic hit;
  assign hit = (cnt_q >= limit);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (hit) begin
      done_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign done = done_q;
endmodule : lbrs_timer

/* logic/lbrs_seq.sv */
`timescale 1ns/10ps
module lbrs_seq #(
  parameter int LSS_STEP_CYC_P = lbrs_pkg::LSS_STEP_CYC,
  parameter int BSS_MIN_CYC_P = lbrs_pkg::BSS_MIN_CYC,
  parameter int BSS_STEP_CYC_P = lbrs_pkg::BSS_STEP_CYC,
  parameter int DLY_STEP_CYC_P = lbrs_pkg::DLY_STEP_CYC
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic UNDERVOLTAGE_LOCKOUT_N,
  input wire logic EN,
  input wire logic RESET_RELEASED,
  input wire logic THERMISTOR_INPUT_GND,
  input wire logic [lbrs_pkg::AV_W-1:0] ANALOG_RAIL_SETTING,
  input wire logic [lbrs_pkg::CORE_W-1:0] CORE_LOGIC_RAIL_SET,
  input wire logic [lbrs_pkg::IO_W-1:0] IO_LEVEL_SELECT,
  input wire logic [lbrs_pkg::SS_W-1:0] LOGIC_SOFT_START_TIME,
  input wire logic [lbrs_pkg::SS_W-1:0] BOOST_SOFT_START_TIME,
  input wire logic [lbrs_pkg::DLY_W-1:0] ANALOG_RAIL_START_DELAY,
  input wire logic [lbrs_pkg::GH_W-1:0] GATE_HOT_LEVEL,
  input wire logic [lbrs_pkg::GH_W-1:0] GATE_COLD_LEVEL,
  output logic CORE_LOGIC_RAIL_EN,
  output logic CORE_LOGIC_RAIL_DISCH,
  output logic [lbrs_pkg::CORE_W-1:0] CORE_LOGIC_RAIL_LVL,
  output logic IO_RAIL_PRIMARY_EN,
  output logic IO_RAIL_PRIMARY_DISCH,
  output logic [lbrs_pkg::IO_W-1:0] IO_RAIL_PRIMARY_LVL,
  output logic IO_RAIL_SECONDARY_EN,
  output logic IO_RAIL_SECONDARY_LVL,
  output logic LOGIC_RAMP_DONE,
  output logic ANALOG_RAIL_EN,
  output logic [lbrs_pkg::AV_W-1:0] ANALOG_RAIL_LVL,
  output logic ANALOG_RAMP_DONE,
  output logic GATE_HIGH_RAIL_EN,
  output logic GATE_HIGH_RAIL_DISCH,
  output logic [lbrs_pkg::GH_W-1:0] GATE_HOT_LVL,
  output logic [lbrs_pkg::GH_W-1:0] GATE_COLD_LVL,
  output logic GATE_COMP_EN,
  output logic GATE_RAMP_DONE
);
  import lbrs_pkg::*;

  logic rst_n;
  lbrs_rst_sync u_rst (
    .clk(CLK),
    .rst_async_n(RSTN),
    .rst_n(rst_n)
  );

  // Registered copies of the supply, enable and reset inputs.
  logic pwr_q;
  logic en_q;
  logic rel_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= 1'b0;
      en_q <= 1'b0;
      rel_q <= 1'b0;
    end else begin
      pwr_q <= UNDERVOLTAGE_LOCKOUT_N;
      en_q <= EN;
      rel_q <= RESET_RELEASED;
    end
  end

  // Level settings start at their factory values and track
  // the setting inputs from the first cycle after reset.
  logic [AV_W-1:0] av_lvl_q;
  logic [CORE_W-1:0] core_lvl_q;
  logic [IO_W-1:0] io_lvl_q;
  logic [GH_W-1:0] hot_q;
  logic [GH_W-1:0] cold_q;
  logic comp_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      av_lvl_q <= AV_DEF;
      core_lvl_q <= CORE_DEF;
      io_lvl_q <= IO_DEF;
      hot_q <= GH_DEF;
      cold_q <= GH_DEF;
      comp_q <= 1'b0;
    end else begin
      av_lvl_q <= ANALOG_RAIL_SETTING;
      core_lvl_q <= CORE_LOGIC_RAIL_SET;
      io_lvl_q <= IO_LEVEL_SELECT;
      hot_q <= GATE_HOT_LEVEL;
      cold_q <= GATE_COLD_LEVEL;
      comp_q <= !THERMISTOR_INPUT_GND;
    end
  end

  // Enable history: a fall of enable after it was seen high
  // latches the boost rails off until the supply drops out.
  logic en_seen_q;
  logic en_seen_d;
  logic en_fall;
  assign en_fall = en_seen_q && !en_q;
  assign en_seen_d = pwr_q && (en_seen_q || en_q);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      en_seen_q <= 1'b0;
    end else begin
      en_seen_q <= en_seen_d;
    end
  end

  // Soft-start and delay limits, in cycles minus one.
  logic [CNT_W-1:0] lss_lim;
  logic [CNT_W-1:0] bss_lim;
  logic [CNT_W-1:0] dly_lim;
  logic dly_zero;
  assign lss_lim = CNT_W'(
    (int'(LOGIC_SOFT_START_TIME) + 1) * LSS_STEP_CYC_P - 1);
  assign bss_lim = CNT_W'(BSS_MIN_CYC_P +
    int'(BOOST_SOFT_START_TIME) * BSS_STEP_CYC_P - 1);
  assign dly_zero = (ANALOG_RAIL_START_DELAY == '0);
  assign dly_lim = dly_zero ? '0 : CNT_W'(
    int'(ANALOG_RAIL_START_DELAY) * DLY_STEP_CYC_P - 1);

  // Sequencer for the boost rails.
  lbrs_state_t state_q;
  lbrs_state_t state_d;
  logic dly_done;
  logic av_done;
  logic gh_done;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (en_q && rel_q) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          state_d = ST_AV_RAMP;
        end
      end
      ST_AV_RAMP: begin
        if (av_done) begin
          state_d = ST_GH_RAMP;
        end
      end
      ST_GH_RAMP: begin
        if (gh_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      ST_SHUT: begin
        state_d = ST_SHUT;
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (!pwr_q) begin
      state_d = ST_OFF;
    end else if (en_fall && state_q != ST_OFF) begin
      state_d = ST_SHUT;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Timer run terms: the logic term is the registered supply, the rest are decoded from the state flops.
  logic logic_run;
  logic dly_run;
  logic av_run;
  logic gh_run;
  assign logic_run = pwr_q;
  assign dly_run = (state_q == ST_DELAY);
  assign gh_run = (state_q == ST_GH_RAMP) || (state_q == ST_RUN);
  assign av_run = (state_q == ST_AV_RAMP) || gh_run;

  logic logic_done;
  // One timer paces core, primary I/O and LDO together.
  lbrs_timer u_lss (
    .clk(CLK),
    .rst_n(rst_n),
    .run(logic_run),
    .limit(lss_lim),
    .done(logic_done)
  );

  lbrs_timer u_dly (
    .clk(CLK),
    .rst_n(rst_n),
    .run(dly_run),
    .limit(dly_lim),
    .done(dly_done)
  );

  // Both boost timers take the same limit, so a change of
  // the boost soft-start setting moves both ramps.
  lbrs_timer u_ss_av (
    .clk(CLK),
    .rst_n(rst_n),
    .run(av_run),
    .limit(bss_lim),
    .done(av_done)
  );

  lbrs_timer u_ss_gh (
    .clk(CLK),
    .rst_n(rst_n),
    .run(gh_run),
    .limit(bss_lim),
    .done(gh_done)
  );

  // Logic rails.
  logic ldo_on;
  assign ldo_on = io_lvl_q[IO_LDO_BIT];
  assign CORE_LOGIC_RAIL_EN = pwr_q;
  // The core rail never discharges; it only stops switching.
  assign CORE_LOGIC_RAIL_DISCH = 1'b0;
  assign CORE_LOGIC_RAIL_LVL = core_lvl_q;
  assign IO_RAIL_PRIMARY_EN = pwr_q;
  assign IO_RAIL_PRIMARY_DISCH = !pwr_q;
  assign IO_RAIL_PRIMARY_LVL = ldo_on ? IO1_OUT_2V5 :
    {1'b0, io_lvl_q[0]};
  assign IO_RAIL_SECONDARY_EN = pwr_q && ldo_on;
  assign IO_RAIL_SECONDARY_LVL = io_lvl_q[0];
  assign LOGIC_RAMP_DONE = logic_done;

  // Boost rails.
  assign ANALOG_RAIL_EN = av_run;
  assign ANALOG_RAIL_LVL = av_lvl_q;
  assign ANALOG_RAMP_DONE = av_done;
  assign GATE_HIGH_RAIL_EN = gh_run;
  // The gate rail is left to bleed through its load.
  assign GATE_HIGH_RAIL_DISCH = 1'b0;
  assign GATE_HOT_LVL = hot_q;
  assign GATE_COLD_LVL = cold_q;
  assign GATE_COMP_EN = comp_q;
  assign GATE_RAMP_DONE = gh_done;

  // Helper counters that time the ramps for the checks.
  logic [CNT_W-1:0] lg_cnt_q;
  logic [CNT_W-1:0] av_cnt_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      lg_cnt_q <= '0;
      av_cnt_q <= '0;
    end else begin
      lg_cnt_q <= logic_run ? lg_cnt_q + 1'b1 : '0;
      av_cnt_q <= av_run ? av_cnt_q + 1'b1 : '0;
    end
  end

  chk_logic_start: assert property (
    @(posedge CLK) disable iff (!rst_n)
    $rose(pwr_q) |-> CORE_LOGIC_RAIL_EN && IO_RAIL_PRIMARY_EN
      && (IO_RAIL_SECONDARY_EN == io_lvl_q[IO_LDO_BIT]))
    else $error("logic rails did not start together");

  chk_logic_ramp: assert property (
    @(posedge CLK) disable iff (!rst_n)
    $rose(LOGIC_RAMP_DONE) && $stable(LOGIC_SOFT_START_TIME)
      |-> lg_cnt_q == lss_lim + 1'b1)
    else $error("logic ramp length wrong");

  chk_core_off: assert property (
    @(posedge CLK) disable iff (!rst_n)
    $fell(pwr_q) |-> !CORE_LOGIC_RAIL_EN && !CORE_LOGIC_RAIL_DISCH)
    else $error("core rail discharged or still on");

  chk_ldo_blocked: assert property (
    @(posedge CLK) disable iff (!rst_n)
    $past(IO_LEVEL_SELECT[IO_LDO_BIT]) == 1'b0
      |-> !IO_RAIL_SECONDARY_EN)
    else $error("LDO on with low primary level");

  chk_io_disch: assert property (
    @(posedge CLK) disable iff (!rst_n)
    !UNDERVOLTAGE_LOCKOUT_N |=> IO_RAIL_PRIMARY_DISCH
      && !IO_RAIL_PRIMARY_EN)
    else $error("primary I/O not discharged");

  chk_gate_after: assert property (
    @(posedge CLK) disable iff (!rst_n)
    $rose(GATE_HIGH_RAIL_EN) |-> $past(ANALOG_RAMP_DONE))
    else $error("gate rail before analog ramp end");

  chk_boost_ramp: assert property (
    @(posedge CLK) disable iff (!rst_n)
    $rose(ANALOG_RAMP_DONE) && $stable(BOOST_SOFT_START_TIME)
      |-> av_cnt_q == bss_lim + 1'b1)
    else $error("boost ramp length wrong");

  chk_gate_off: assert property (
    @(posedge CLK) disable iff (!rst_n)
    (!pwr_q || en_fall) |=> !GATE_HIGH_RAIL_EN && !ANALOG_RAIL_EN)
    else $error("boost rails not switched off");

  chk_latch_hold: assert property (
    @(posedge CLK) disable iff (!rst_n)
    state_q == ST_SHUT && UNDERVOLTAGE_LOCKOUT_N
      |=> !GATE_HIGH_RAIL_EN [*2])
    else $error("gate rail restarted after enable low");

  chk_gate_nodis: assert property (
    @(posedge CLK) disable iff (!rst_n)
    $fell(GATE_HIGH_RAIL_EN) |-> !GATE_HIGH_RAIL_DISCH)
    else $error("gate rail discharge switched on");

  chk_hot_only: assert property (
    @(posedge CLK) disable iff (!rst_n)
    THERMISTOR_INPUT_GND |=> !GATE_COMP_EN)
    else $error("compensation on with grounded input");

  chk_start_delay: assert property (
    @(posedge CLK) disable iff (!rst_n)
    $rose(ANALOG_RAIL_EN) |-> $past(dly_done) && $past(en_q)
      && $past(rel_q))
    else $error("analog rail started without delay");

  chk_ldo_level: assert property (
    @(posedge CLK) disable iff (!rst_n)
    IO_RAIL_SECONDARY_EN |-> IO_RAIL_PRIMARY_EN
      && IO_RAIL_PRIMARY_LVL == IO1_OUT_2V5)
    else $error("LDO on while primary below 2.5 V");

  chk_gate_gated: assert property (
    @(posedge CLK) disable iff (!rst_n)
    GATE_HIGH_RAIL_EN |-> ANALOG_RAIL_EN
      && ANALOG_RAMP_DONE)
    else $error("gate rail on before analog ramp done");

  chk_level_track: assert property (
    @(posedge CLK) disable iff (!rst_n)
    ANALOG_RAIL_LVL == $past(ANALOG_RAIL_SETTING)
      && CORE_LOGIC_RAIL_LVL == $past(CORE_LOGIC_RAIL_SET))
    else $error("rail level does not follow its setting");
endmodule : lbrs_seq

/* tb/lbrs_stage_model.sv */
`timescale 1ns/10ps
// Far side of the sequencer: the supply monitor, the system enable driver
// and the reset generator that follows the core rail.
module lbrs_stage_model #(
  parameter int RST_CYC = 6
) (
  input wire logic clk,
  input wire logic supply_req,
  input wire logic en_req,
  input wire logic core_ramp_done,
  output logic lockout_n,
  output logic en,
  output logic reset_released
);
  int cnt;

  initial begin
    lockout_n = 1'b0;
    en = 1'b0;
    reset_released = 1'b0;
    cnt = 0;
  end

  // The reset output only starts counting once the core rail has ramped,
  // and once released it stays high until the supply drops away.
  // The bench moves its requests on the falling edge, so this side answers
  // on the rising edge; that keeps the lag one fixed cycle, free of races.
  always @(posedge clk) begin
    lockout_n <= supply_req;
    en <= en_req;
    if (!supply_req) begin
      cnt <= 0;
      reset_released <= 1'b0;
    end else if (core_ramp_done && cnt < RST_CYC) begin
      cnt <= cnt + 1;
    end else if (cnt == RST_CYC) begin
      reset_released <= 1'b1;
    end
  end
endmodule : lbrs_stage_model

/* tb/test_lcd_bias_rail_sequencer.sv */
`timescale 1ns/10ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  n_fail++; $display("unexpected at %0t: got %h expected %h", $time, \
  got, exp); end end

module test_lcd_bias_rail_sequencer;
  // Shortened step counts keep the run brief; expectations follow them.
  localparam int LSS_S = 4;
  localparam int BSS_M = 16;
  localparam int BSS_S = 4;
  localparam int DLY_S = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic supply_req = 1'b0;
  logic en_req = 1'b0;
  logic therm_gnd = 1'b1;
  logic [4:0] av = 5'h0e;
  logic [1:0] core = 2'h1;
  logic [1:0] io = 2'h0;
  logic [2:0] lss = 3'h0;
  logic [2:0] bss = 3'h0;
  logic [2:0] dly = 3'h0;
  logic [3:0] hot = 4'h0;
  logic [3:0] cold = 4'h0;
  wire lockout_n, en, rst_rel;
  logic core_en, core_dis, io_en, io_dis, sec_en, sec_lvl, logic_done;
  logic av_en, av_done, gh_en, gh_dis, comp_en, gh_done;
  logic [1:0] core_lvl, io_lvl;
  logic [4:0] av_lvl;
  logic [3:0] hot_lvl, cold_lvl;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 1;
  int t[7];
  wire [6:0] ev = {gh_done, gh_en, av_done, av_en, en & rst_rel,
                   logic_done, core_en};

  always #12.5 clk = ~clk;

  lbrs_stage_model stage (.clk(clk), .supply_req(supply_req),
    .en_req(en_req), .core_ramp_done(logic_done),
    .lockout_n(lockout_n), .en(en), .reset_released(rst_rel));

  lbrs_seq #(.LSS_STEP_CYC_P(LSS_S), .BSS_MIN_CYC_P(BSS_M),
    .BSS_STEP_CYC_P(BSS_S), .DLY_STEP_CYC_P(DLY_S)) uut (
    .CLK(clk), .RSTN(rstn), .UNDERVOLTAGE_LOCKOUT_N(lockout_n), .EN(en),
    .RESET_RELEASED(rst_rel), .THERMISTOR_INPUT_GND(therm_gnd),
    .ANALOG_RAIL_SETTING(av), .CORE_LOGIC_RAIL_SET(core),
    .IO_LEVEL_SELECT(io), .LOGIC_SOFT_START_TIME(lss),
    .BOOST_SOFT_START_TIME(bss), .ANALOG_RAIL_START_DELAY(dly),
    .GATE_HOT_LEVEL(hot), .GATE_COLD_LEVEL(cold),
    .CORE_LOGIC_RAIL_EN(core_en), .CORE_LOGIC_RAIL_DISCH(core_dis),
    .CORE_LOGIC_RAIL_LVL(core_lvl), .IO_RAIL_PRIMARY_EN(io_en),
    .IO_RAIL_PRIMARY_DISCH(io_dis), .IO_RAIL_PRIMARY_LVL(io_lvl),
    .IO_RAIL_SECONDARY_EN(sec_en), .IO_RAIL_SECONDARY_LVL(sec_lvl),
    .LOGIC_RAMP_DONE(logic_done), .ANALOG_RAIL_EN(av_en),
    .ANALOG_RAIL_LVL(av_lvl), .ANALOG_RAMP_DONE(av_done),
    .GATE_HIGH_RAIL_EN(gh_en), .GATE_HIGH_RAIL_DISCH(gh_dis),
    .GATE_HOT_LVL(hot_lvl), .GATE_COLD_LVL(cold_lvl),
    .GATE_COMP_EN(comp_en), .GATE_RAMP_DONE(gh_done));

  // First edge at which each sequence event is seen high.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 7; i++) begin
      if (ev[i] && t[i] == 0) t[i] <= cyc;
    end
  end

  function automatic logic near(int got, int exp, int tol);
    return (got >= exp - tol) && (got <= exp + tol);
  endfunction : near

  task automatic cyc_wait(int n);
    repeat (n) @(negedge clk);
  endtask : cyc_wait

  task automatic check_reset;
    `CHECK(av_lvl, 5'h0e)
    `CHECK(core_lvl, 2'h1)
    `CHECK(io_lvl, 2'h0)
    `CHECK(sec_en, 1'b0)
    `CHECK({core_en, io_en, av_en, gh_en}, 4'h0)
    `CHECK(io_dis, 1'b1)
  endtask : check_reset

  task automatic power_up(input logic [2:0] s1, s2, d);
    lss = s1;
    bss = s2;
    dly = d;
    en_req = 1'b0;
    for (int i = 0; i < 7; i++) t[i] = 0;
    supply_req = 1'b1;
    cyc_wait(3);
    `CHECK({core_en, io_en, sec_en}, {2'b11, io[1]})
    `CHECK(av_en, 1'b0)
    for (int k = 0; k < 200 && !logic_done; k++) cyc_wait(1);
    // Event times are logged at the next rising edge; let it pass first.
    cyc_wait(1);
    `CHECK(near(t[1] - t[0], (s1 + 1) * LSS_S, 1), 1'b1)
    en_req = 1'b1;
    for (int k = 0; k < 3000 && !gh_done; k++) cyc_wait(1);
    cyc_wait(1);
    `CHECK(near(t[3] - t[2], d * DLY_S + 3, 2), 1'b1)
    `CHECK(near(t[4] - t[3], BSS_M + s2 * BSS_S, 2), 1'b1)
    `CHECK(t[5] > t[4] && t[5] <= t[4] + 2, 1'b1)
    `CHECK(near(t[6] - t[5], BSS_M + s2 * BSS_S, 2), 1'b1)
  endtask : power_up

  task automatic levels;
    for (int i = 0; i < 4; i++) begin
      io = i[1:0];
      cyc_wait(3);
      `CHECK(io_lvl, i[1] ? 2'h2 : i[1:0])
      `CHECK(sec_en, i[1])
      `CHECK(sec_lvl, i[0])
    end
    io = 2'h0;
    av = 5'h00;
    core = 2'h3;
    hot = 4'hf;
    cold = 4'h0;
    therm_gnd = 1'b1;
    cyc_wait(3);
    `CHECK({av_lvl, core_lvl, comp_en}, {5'h00, 2'h3, 1'b0})
    `CHECK({hot_lvl, cold_lvl}, 8'hf0)
    av = 5'h1f;
    hot = 4'h0;
    cold = 4'hf;
    therm_gnd = 1'b0;
    cyc_wait(3);
    `CHECK({av_lvl, comp_en}, {5'h1f, 1'b1})
    `CHECK({hot_lvl, cold_lvl}, 8'h0f)
  endtask : levels

  task automatic en_drop;
    en_req = 1'b0;
    cyc_wait(4);
    `CHECK({av_en, gh_en, gh_dis, core_en}, 4'h1)
    en_req = 1'b1;
    cyc_wait(100);
    `CHECK({av_en, gh_en}, 2'h0)
  endtask : en_drop

  task automatic supply_drop;
    supply_req = 1'b0;
    cyc_wait(4);
    `CHECK({core_en, core_dis}, 2'h0)
    `CHECK({io_en, io_dis, sec_en}, 3'h2)
    `CHECK({av_en, gh_en, gh_dis}, 3'h0)
    cyc_wait(10);
  endtask : supply_drop

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    cyc_wait(2);
    check_reset;
    cyc_wait(2);
    rstn = 1'b1;
    cyc_wait(3);
    power_up(3'h0, 3'h0, 3'h0);
    levels;
    en_drop;
    supply_drop;
    // A full power-down must clear the enable latch.
    power_up(3'h7, 3'h7, 3'h2);
    supply_drop;
    finish_test;
  end

  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test;
  end
endmodule : test_lcd_bias_rail_sequencer
